// >>> dv/rwl_host_model.sv
// host and microcore request driver facing the lock unit
`timescale 1ns/1ps
module rwl_host_model (
    // clock
    input wire logic ref_clk,
    // requests toward the unit
    output logic regWrEn,
    output logic [9:0] regWrAddr,
    output logic [15:0] regWrData,
    output logic regWrLockable,
    output logic regWrRamOneTail,
    output logic regWrRamTwoTail,
    output logic regRdEn,
    output logic regRdExternal,
    output logic [9:0] regRdAddr,
    output logic ucWrEn,
    output logic [9:0] ucWrAddr
);
    // idle values at time zero
    initial
    begin
        {regWrEn, regWrLockable, regWrRamOneTail, regWrRamTwoTail} = 4'h0;
        {regRdEn, regRdExternal, ucWrEn} = 3'h0;
        {regWrAddr, regRdAddr, ucWrAddr, regWrData} = 46'h0;
    end
    // one write after an idle cycle; the answer stands on return until
    // the next rising edge; f = {tail2, tail1, lockable}
    task wr(input logic [9:0] a, input logic [15:0] d, input logic [2:0] f);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regWrAddr = a;
        regWrData = d;
        {regWrRamTwoTail, regWrRamOneTail, regWrLockable} = f;
        @(negedge ref_clk);
        regWrEn = 1'b0;
        regWrAddr = ~a; // released lines never hold the old value
        regWrData = ~d;
        {regWrRamTwoTail, regWrRamOneTail, regWrLockable} = 3'h0;
    endtask
    // one read after an idle cycle, optionally colliding with a microcore
    // write; the answer stands on return until the next rising edge
    task rd(input logic [9:0] a, input logic ext, input logic uc);
        @(negedge ref_clk);
        regRdEn = 1'b1;
        regRdExternal = ext;
        regRdAddr = a;
        ucWrEn = uc;
        ucWrAddr = a;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        regRdAddr = ~a;
        ucWrEn = 1'b0;
        ucWrAddr = ~a;
    endtask
endmodule

// >>> dv/rwl_lock_unit_checker.sv
// concurrent checks on the lock unit top ports
`timescale 1ns/1ps
module rwl_lock_unit_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // requests
    input wire logic regWrEn,
    input wire logic [9:0] regWrAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrLockable,
    input wire logic regWrRamOneTail,
    input wire logic regWrRamTwoTail,
    input wire logic regRdEn,
    input wire logic regRdExternal,
    input wire logic [9:0] regRdAddr,
    input wire logic ucWrEn,
    input wire logic [9:0] ucWrAddr,
    // answers
    input wire logic wrGrant,
    input wire logic regRdValid,
    input wire logic [15:0] regRdData,
    input wire logic globalLock,
    input wire logic ramOneTailGuard,
    input wire logic ramTwoTailGuard,
    input wire logic driveStatusClear,
    input wire logic [3:0] diagClear,
    input wire logic [3:0] statClear
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic keyWr;
    logic [8:0] clrAll;
    // correct key written to the unlock place
    assign keyWr = regWrEn && regWrAddr == 10'h1CF && regWrData == 16'h1337;
    assign clrAll = {statClear, diagClear, driveStatusClear};
    sequence sBackdoorRd;
        regRdEn && !regRdExternal;
    endsequence
    sequence sCollideRd;
        regRdEn && regRdExternal && regRdAddr == 10'h162
            && ucWrEn && ucWrAddr == 10'h162;
    endsequence
    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    a_lock_set: assert property (regWrEn && regWrAddr == 10'h1CD
        && regWrData[0] |=> globalLock) else $error("lock not set");
    a_lock_block: assert property (globalLock && regWrEn && regWrLockable
        && !regWrRamOneTail && !regWrRamTwoTail |=> !wrGrant)
        else $error("locked write granted");
    a_lock_hold: assert property (globalLock && !keyWr |=> globalLock)
        else $error("lock lost without key");
    a_key_clears: assert property (keyWr |=> !globalLock
        && !ramOneTailGuard && !ramTwoTailGuard) else $error("key no clear");
    a_tail_free: assert property (!ramOneTailGuard && regWrEn
        && regWrRamOneTail && regWrAddr < 10'h1CD
        && !(regWrRamTwoTail && ramTwoTailGuard) |=> wrGrant)
        else $error("free tail write refused");
    a_tail_guard: assert property (ramTwoTailGuard && regWrEn
        && regWrRamTwoTail |=> !wrGrant) else $error("guarded tail granted");
    a_guard_self: assert property (ramOneTailGuard && !keyWr
        |=> ramOneTailGuard) else $error("tail guard lost");
    a_clear_cause: assert property (|clrAll
        |-> $past(regRdEn && regRdExternal)) else $error("stray clear");
    a_backdoor_quiet: assert property (sBackdoorRd |=> clrAll == 9'h000)
        else $error("backdoor read cleared");
    a_collide_keep: assert property (sCollideRd |=> !diagClear[0])
        else $error("clear during collision");
    a_cfg_read: assert property (regRdEn && regRdAddr == 10'h1CE
        |=> regRdValid && regRdData[15:9] == 7'h00)
        else $error("config read wrong");
endmodule
bind rwl_lock_unit rwl_lock_unit_checker rwl_lock_unit_checker_inst (
    .ref_clk(ref_clk), .rst(rst), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regWrLockable(regWrLockable),
    .regWrRamOneTail(regWrRamOneTail), .regWrRamTwoTail(regWrRamTwoTail),
    .regRdEn(regRdEn), .regRdExternal(regRdExternal), .regRdAddr(regRdAddr),
    .ucWrEn(ucWrEn), .ucWrAddr(ucWrAddr), .wrGrant(wrGrant),
    .regRdValid(regRdValid), .regRdData(regRdData), .globalLock(globalLock),
    .ramOneTailGuard(ramOneTailGuard), .ramTwoTailGuard(ramTwoTailGuard),
    .driveStatusClear(driveStatusClear), .diagClear(diagClear),
    .statClear(statClear)
);

// >>> dv/tb.sv
// self-checking bench for the lock and read-clear unit
`timescale 1ns/1ps
module tb;
    logic ref_clk, rst, regWrEn, regWrLockable, regWrRamOneTail;
    logic regWrRamTwoTail, regRdEn, regRdExternal, ucWrEn, wrGrant;
    logic regRdValid, globalLock, ramOneTailGuard, ramTwoTailGuard;
    logic driveStatusClear;
    logic [9:0] regWrAddr, regRdAddr, ucWrAddr, wrGrantAddr;
    logic [15:0] regWrData, wrGrantData, regRdData;
    logic [3:0] diagClear, statClear;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    // -----------------------------------------------------------------
    // clock, timeout and instances
    // -----------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            wrap_up();
        end
    end
    rwl_host_model host_inst (.*);
    rwl_lock_unit rwl_lock_unit_inst (.*);
    // compare and report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up();
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        host_inst.rd(10'h1CD, 1'b1, 1'b0);
        chk(regRdData, 16'h0000);
        host_inst.wr(10'h1CE, 16'hFFFF, 3'h0);
        host_inst.rd(10'h1CE, 1'b1, 1'b0);
        chk({regRdValid, regRdData}, 17'h101FF);
        for (int i = 0; i < 9; i++)
        begin
            host_inst.rd(rwl_pkg::RWL_CLR_ADDR_A[i], 1'b1, 1'b0);
            chk({statClear, diagClear, driveStatusClear}, 16'h0001 << i);
            host_inst.rd(rwl_pkg::RWL_CLR_ADDR_B[i], 1'b1, 1'b0);
            chk({statClear, diagClear, driveStatusClear}, 16'h0001 << i);
        end
        host_inst.rd(10'h163, 1'b0, 1'b0);
        chk(diagClear, 16'h0000);
        host_inst.rd(10'h162, 1'b1, 1'b1);
        chk(diagClear, 16'h0000);
        host_inst.rd(10'h162, 1'b1, 1'b0);
        chk(diagClear, 16'h0001);
        host_inst.wr(10'h1CE, 16'h0000, 3'h0);
        host_inst.rd(10'h169, 1'b1, 1'b0);
        chk(diagClear, 16'h0000);
        host_inst.wr(10'h0A5, 16'hBEEF, 3'h1);
        chk({wrGrant, wrGrantAddr, wrGrantData},
            {1'b1, 10'h0A5, 16'hBEEF});
        host_inst.wr(10'h1CD, 16'h0001, 3'h0);
        chk({globalLock, wrGrant}, 16'h0002);
        host_inst.wr(10'h0A5, 16'h1234, 3'h1);
        chk(wrGrant, 16'h0000);
        host_inst.wr(10'h0F0, 16'h1234, 3'h3);
        chk(wrGrant, 16'h0001);
        host_inst.wr(10'h1CD, 16'h0000, 3'h0);
        host_inst.rd(10'h1CD, 1'b1, 1'b0);
        chk(regRdData, 16'h0001);
        host_inst.wr(10'h1CD, 16'h0006, 3'h0);
        chk({ramTwoTailGuard, ramOneTailGuard}, 16'h0003);
        host_inst.wr(10'h0F0, 16'h1234, 3'h2);
        chk(wrGrant, 16'h0000);
        host_inst.wr(10'h0FF, 16'h1234, 3'h4);
        chk(wrGrant, 16'h0000);
        host_inst.wr(10'h1CD, 16'h0000, 3'h0);
        chk({ramTwoTailGuard, ramOneTailGuard}, 16'h0003);
        host_inst.wr(10'h1CF, 16'h1336, 3'h0);
        chk(globalLock, 16'h0001);
        host_inst.wr(10'h1CF, 16'h1337, 3'h0);
        host_inst.rd(10'h1CD, 1'b1, 1'b0);
        chk({globalLock, ramOneTailGuard, regRdData}, 16'h0000);
        host_inst.rd(10'h1CF, 1'b1, 1'b0);
        chk(regRdData, 16'h0000);
        host_inst.rd(10'h1D0, 1'b1, 1'b0);
        chk(regRdValid, 16'h0000);
        // a reset in mid-run is the other way back to unlocked
        host_inst.wr(10'h1CD, 16'h0007, 3'h0);
        chk({globalLock, ramOneTailGuard, ramTwoTailGuard}, 32'h7);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        chk({globalLock, ramOneTailGuard, ramTwoTailGuard}, 32'h0);
        wrap_up();
    end
endmodule

// >>> shared/rwl_pkg.sv
// constants and state types for the register write lock and read-clear unit
package rwl_pkg;

    // ------------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------------
    localparam int RWL_ADDR_W = 10;
    localparam int RWL_DATA_W = 16;
    localparam int RWL_CLR_N = 9;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] RWL_WRITE_PROTECT_CONTROL_ADDR = 10'h1CD;
    localparam logic [9:0] RWL_READ_CLEAR_CONFIG_ADDR = 10'h1CE;
    localparam logic [9:0] RWL_UNLOCK_KEY_ADDR = 10'h1CF;

    // ------------------------------------------------------------------
    // write_protect_control fields and reset value
    // ------------------------------------------------------------------
    localparam int RWL_GLOBAL_LOCK_BIT = 0;
    localparam int RWL_RAM_ONE_TAIL_GUARD_BIT = 1;
    localparam int RWL_RAM_TWO_TAIL_GUARD_BIT = 2;
    localparam int RWL_LOCK_W = 3;
    localparam logic [2:0] RWL_LOCK_RESET = 3'h0;

    // ------------------------------------------------------------------
    // read_clear_config fields and reset value
    // ------------------------------------------------------------------
    localparam int RWL_DRIVE_STATUS_CLEAR_ON_READ_BIT = 0;
    localparam int RWL_DIAG_FIRST_BIT = 1;
    localparam int RWL_STAT_FIRST_BIT = 5;
    localparam logic [8:0] RWL_READ_CLEAR_RESET = 9'h000;

    // ------------------------------------------------------------------
    // unlock key value
    // ------------------------------------------------------------------
    localparam logic [15:0] RWL_UNLOCK_KEY_VALUE = 16'h1337;

    // ------------------------------------------------------------------
    // read-clear targets, entry i is enabled by config bit i
    // each entry names a pair of addresses; single targets repeat one
    // ------------------------------------------------------------------
    localparam logic [8:0][9:0] RWL_CLR_ADDR_A = {
        10'h1E3, 10'h1E2, 10'h1E1, 10'h1E0,
        10'h168, 10'h166, 10'h164, 10'h162,
        10'h1E4
    };
    localparam logic [8:0][9:0] RWL_CLR_ADDR_B = {
        10'h1E3, 10'h1E2, 10'h1E1, 10'h1E0,
        10'h169, 10'h167, 10'h165, 10'h163,
        10'h1E4
    };

    // ------------------------------------------------------------------
    // unit state, one register set
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] lock;
        logic [8:0] clrCfg;
        logic [15:0] rdData;
        logic rdValid;
        logic wrGrant;
        logic [9:0] wrAddr;
        logic [15:0] wrData;
        logic [8:0] clr;
    } rwl_state_t;

endpackage

// >>> shared/rwl_rd_if.sv
// read-clear decode signals between the unit and its decoder
`timescale 1ns/1ps
interface rwl_rd_if;
    logic rdEn;
    logic rdExternal;
    logic [9:0] rdAddr;
    logic ucWrEn;
    logic [9:0] ucWrAddr;
    logic [8:0] clrCfg;
    logic [8:0] clrHit;

    modport unit (
        output rdEn,
        output rdExternal,
        output rdAddr,
        output ucWrEn,
        output ucWrAddr,
        output clrCfg,
        input clrHit
    );

    modport decoder (
        input rdEn,
        input rdExternal,
        input rdAddr,
        input ucWrEn,
        input ucWrAddr,
        input clrCfg,
        output clrHit
    );
endinterface

// >>> verilog/rwl_clear_decode.sv
// decoder that picks which status registers clear on an external read
`timescale 1ns/1ps
module rwl_clear_decode (
    // decode request and result
    rwl_rd_if.decoder rd
);

    // ------------------------------------------------------------------
    // per target decode
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < rwl_pkg::RWL_CLR_N; i = i + 1)
        begin : gTarget
            logic rdHit;
            logic ucHit;
            // read address hits either address of the pair
            assign rdHit = (rd.rdAddr == rwl_pkg::RWL_CLR_ADDR_A[i])
                || (rd.rdAddr == rwl_pkg::RWL_CLR_ADDR_B[i]);
            // microcore writes the very register being read
            assign ucHit = rd.ucWrEn && (rd.ucWrAddr == rd.rdAddr);
            // only external reads clear, backdoor reads never do
            assign rd.clrHit[i] = rd.rdEn && rd.rdExternal // R8
                && rd.clrCfg[i] && rdHit // R7
                && !ucHit; // R12
        end
    endgenerate

endmodule

// >>> verilog/rwl_lock_unit.sv
// register write lock and clear-on-read configuration unit
//
// Function
// [R1] writing one to bit zero locks
// [R2] lock blocks writes to lockable registers only
// [R3] writing zero never clears global lock
// [R4] key 0x1337 clears whole lock register
// [R5] global lock leaves ram tails alone
// [R6] bits one, two guard each ram tail
// [R7] config bits enable clear on external read
// [R8] backdoor microcore reads never clear anything
// [R9] bit zero clears drive status on read
// [R10] four bits clear diagnosis error pairs
// [R11] bits five to eight clear core status
// [R12] read colliding with microcore write keeps update
// [R13] tail guard bits protect themselves once set
`timescale 1ns/1ps
module rwl_lock_unit (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register write request from the serial slave
    input wire logic regWrEn,
    input wire logic [9:0] regWrAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrLockable,
    input wire logic regWrRamOneTail,
    input wire logic regWrRamTwoTail,
    // register read request
    input wire logic regRdEn,
    input wire logic regRdExternal,
    input wire logic [9:0] regRdAddr,
    // microcore write seen in the same cycle
    input wire logic ucWrEn,
    input wire logic [9:0] ucWrAddr,
    // granted write passed on to the register file
    output logic wrGrant,
    output logic [9:0] wrGrantAddr,
    output logic [15:0] wrGrantData,
    // read answer for this unit's own registers
    output logic regRdValid,
    output logic [15:0] regRdData,
    // lock state
    output logic globalLock,
    output logic ramOneTailGuard,
    output logic ramTwoTailGuard,
    // clear-on-read pulses
    output logic driveStatusClear,
    output logic [3:0] diagClear,
    output logic [3:0] statClear
);

    // ------------------------------------------------------------------
    // state and decode wiring
    // ------------------------------------------------------------------
    rwl_pkg::rwl_state_t state_q;
    rwl_pkg::rwl_state_t state_d;
    rwl_rd_if rdBus ();
    logic wrLockReg;
    logic wrClrReg;
    logic wrKeyReg;
    logic keyMatch;
    logic lockBlocks;
    logic tailOneBlocks;
    logic tailTwoBlocks;
    logic anyTail;
    logic rdLockReg;
    logic rdClrReg;
    logic rdKeyReg;

    // ------------------------------------------------------------------
    // clear-on-read decoder
    // ------------------------------------------------------------------
    // feed the decoder with the current read and microcore write
    assign rdBus.rdEn = regRdEn;
    assign rdBus.rdExternal = regRdExternal;
    assign rdBus.rdAddr = regRdAddr;
    assign rdBus.ucWrEn = ucWrEn;
    assign rdBus.ucWrAddr = ucWrAddr;
    assign rdBus.clrCfg = state_q.clrCfg;

    rwl_clear_decode uDecode (
        .rd (rdBus.decoder)
    );

    // ------------------------------------------------------------------
    // address decode of own registers
    // ------------------------------------------------------------------
    // write strobes for the three registers of this unit
    assign wrLockReg = regWrEn
        && (regWrAddr == rwl_pkg::RWL_WRITE_PROTECT_CONTROL_ADDR);
    assign wrClrReg = regWrEn
        && (regWrAddr == rwl_pkg::RWL_READ_CLEAR_CONFIG_ADDR);
    assign wrKeyReg = regWrEn
        && (regWrAddr == rwl_pkg::RWL_UNLOCK_KEY_ADDR);
    assign keyMatch = wrKeyReg
        && (regWrData == rwl_pkg::RWL_UNLOCK_KEY_VALUE); // R4

    // read selects for the three registers of this unit
    assign rdLockReg = regRdEn
        && (regRdAddr == rwl_pkg::RWL_WRITE_PROTECT_CONTROL_ADDR);
    assign rdClrReg = regRdEn
        && (regRdAddr == rwl_pkg::RWL_READ_CLEAR_CONFIG_ADDR);
    assign rdKeyReg = regRdEn
        && (regRdAddr == rwl_pkg::RWL_UNLOCK_KEY_ADDR);

    // ------------------------------------------------------------------
    // write protection decisions
    // ------------------------------------------------------------------
    // a ram tail write is judged by its own guard only
    assign anyTail = regWrRamOneTail || regWrRamTwoTail;
    // global lock blocks lockable writes outside the ram tails
    assign lockBlocks = state_q.lock[rwl_pkg::RWL_GLOBAL_LOCK_BIT]
        && regWrLockable && !anyTail; // R2 R5
    // each tail guard blocks its own ram tail independently
    assign tailOneBlocks = regWrRamOneTail
        && state_q.lock[rwl_pkg::RWL_RAM_ONE_TAIL_GUARD_BIT]; // R6
    assign tailTwoBlocks = regWrRamTwoTail
        && state_q.lock[rwl_pkg::RWL_RAM_TWO_TAIL_GUARD_BIT]; // R6

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;

        // lock bits only ever go up by writes; zeros leave them set
        if (wrLockReg)
        begin
            state_d.lock[rwl_pkg::RWL_GLOBAL_LOCK_BIT] =
                state_q.lock[rwl_pkg::RWL_GLOBAL_LOCK_BIT]
                | regWrData[rwl_pkg::RWL_GLOBAL_LOCK_BIT]; // R1 R3
            state_d.lock[rwl_pkg::RWL_RAM_ONE_TAIL_GUARD_BIT] =
                state_q.lock[rwl_pkg::RWL_RAM_ONE_TAIL_GUARD_BIT]
                | regWrData[rwl_pkg::RWL_RAM_ONE_TAIL_GUARD_BIT]; // R13
            state_d.lock[rwl_pkg::RWL_RAM_TWO_TAIL_GUARD_BIT] =
                state_q.lock[rwl_pkg::RWL_RAM_TWO_TAIL_GUARD_BIT]
                | regWrData[rwl_pkg::RWL_RAM_TWO_TAIL_GUARD_BIT]; // R13
        end

        // the right key wipes the whole lock register
        if (keyMatch)
        begin
            state_d.lock = rwl_pkg::RWL_LOCK_RESET; // R4
        end

        // read-clear configuration is never locked
        if (wrClrReg)
        begin
            state_d.clrCfg = regWrData[8:0]; // R7
        end

        // other writes pass on unless a lock blocks them
        state_d.wrGrant = regWrEn && !wrLockReg && !wrClrReg
            && !wrKeyReg && !lockBlocks
            && !tailOneBlocks && !tailTwoBlocks; // R2
        state_d.wrAddr = regWrAddr;
        state_d.wrData = regWrData;

        // read answer for own registers; key reads back as zero
        state_d.rdValid = rdLockReg || rdClrReg || rdKeyReg;
        state_d.rdData = 16'h0000;
        if (rdLockReg)
        begin
            state_d.rdData = {13'h0000, state_q.lock};
        end
        else if (rdClrReg)
        begin
            state_d.rdData = {7'h00, state_q.clrCfg};
        end

        // one-cycle clear pulses for enabled external reads
        state_d.clr = rdBus.clrHit; // R9 R10 R11
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q.lock <= rwl_pkg::RWL_LOCK_RESET;
            state_q.clrCfg <= rwl_pkg::RWL_READ_CLEAR_RESET;
            state_q.rdData <= 16'h0000;
            state_q.rdValid <= 1'b0;
            state_q.wrGrant <= 1'b0;
            state_q.wrAddr <= 10'h000;
            state_q.wrData <= 16'h0000;
            state_q.clr <= 9'h000;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------------
    assign wrGrant = state_q.wrGrant;
    assign wrGrantAddr = state_q.wrAddr;
    assign wrGrantData = state_q.wrData;
    assign regRdValid = state_q.rdValid;
    assign regRdData = state_q.rdData;
    assign globalLock = state_q.lock[rwl_pkg::RWL_GLOBAL_LOCK_BIT];
    assign ramOneTailGuard =
        state_q.lock[rwl_pkg::RWL_RAM_ONE_TAIL_GUARD_BIT];
    assign ramTwoTailGuard =
        state_q.lock[rwl_pkg::RWL_RAM_TWO_TAIL_GUARD_BIT];
    assign driveStatusClear =
        state_q.clr[rwl_pkg::RWL_DRIVE_STATUS_CLEAR_ON_READ_BIT];
    assign diagClear = state_q.clr[4:1];
    assign statClear = state_q.clr[8:5];

endmodule
